// file: hdl/transparent_serial_channel_control.sv
// Transparent serial channel: command, error and descriptor control,
// with the receive byte FIFO. Link clocks and line pins are asynchronous.
// How it works
// - CRC check constant used by receiver only
// - Idle transmitter polls descriptor every 64 clocks
// - Abrupt stop aborts buffer, flushes, keeps pointer
// - Graceful stop halts after frame, flags event
// - Resume needs ready descriptor plus restart
// - Restart resumes from current descriptor pointer
// - Init transmit parameters only while disabled
// - Hunt command closes buffer, awaits carrier
// - Close command closes active buffer only
// - Init receive parameters only while disabled
// - Underrun closes buffer, flags it, halts
// - Mid-frame descriptor underrun flags event and halts
// - Clear-to-send loss closes buffer and halts
// - Transfer at 8 or 32 held bits
// - Overrun overwrites byte, closes, enters hunt
// - Carrier loss wins, no CRC or overrun flag set
// - Protocol mode register unused here
// - Errors, full, hunt, close end the buffer
// - Receive descriptor status, length, pointer layout
// - Cleared empty bit hands descriptor to software
// - Event flags write-one-clear; interrupt until cleared
// - Set empty bit keeps descriptor for controller
`timescale 1ns/1ns

module rx_fifo #(
    parameter int W = tsc_pkg::FIFO_W,
    parameter int DEPTH = tsc_pkg::FIFO_DEPTH,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [W-1:0] i_wdata,
    input wire logic i_ovw,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [W-1:0] o_rdata,
    output logic [AW:0] o_count
);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } fifo_st_t;
    fifo_st_t q, n;
    logic wr, rd;

    assign o_wready = (q.cnt != (AW+1)'(DEPTH));
    assign o_rvalid = (q.cnt != '0);
    assign o_rdata = q.mem[q.rp];
    assign o_count = q.cnt;

    // Overwrite replaces the newest entry when full, losing the older byte
    always_comb begin
        n = q;
        wr = i_wvalid && o_wready;
        rd = i_rready && o_rvalid;
        if (wr) begin
            n.mem[q.wp] = i_wdata;
            n.wp = q.wp + 1'b1;
        end else if (i_ovw && o_rvalid) begin
            n.mem[q.wp - 1'b1] = i_wdata;
        end
        if (rd) begin
            n.rp = q.rp + 1'b1;
        end
        if (wr && !rd) begin
            n.cnt = q.cnt + 1'b1;
        end else if (rd && !wr) begin
            n.cnt = q.cnt - 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            q <= '0;
        end else if (i_ce) begin
            q <= n;
        end
    end
endmodule

module transparent_serial_channel_control (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    input wire logic i_tx_en,
    input wire logic i_rx_en,
    input wire logic i_rfw_narrow,
    input wire logic i_tx_on_demand,
    input wire logic i_cmd_valid,
    input wire logic [2:0] i_cmd,
    input wire logic [15:0] i_ev_clr,
    input wire logic [15:0] i_ev_mask,
    input wire logic [15:0] i_crc_preset,
    input wire logic [15:0] i_crc_const,
    input wire logic i_txclk,
    input wire logic i_rxclk,
    input wire logic i_rxd,
    input wire logic i_cts_n,
    input wire logic i_cd_n,
    input wire logic i_txbd_ready,
    input wire logic i_txbd_last,
    input wire logic i_txbd_wrap,
    input wire logic i_txbd_int,
    input wire logic [15:0] i_txbd_len,
    input wire logic i_tx_byte_valid,
    input wire logic [7:0] i_tx_byte,
    input wire logic i_rxbd_wrap,
    input wire logic i_rxbd_int,
    input wire logic i_rxbd_cont,
    input wire logic [15:0] i_rx_max_len,
    input wire logic i_rx_ready,
    output logic o_txd,
    output logic o_tx_poll,
    output logic o_tx_byte_take,
    output logic o_tx_flush,
    output logic o_txbd_close,
    output logic [1:0] o_txbd_status,
    output logic [7:0] o_tx_desc_ptr,
    output logic o_rxbd_len_wr,
    output logic [15:0] o_rxbd_len,
    output logic o_rxbd_status_wr,
    output logic [15:0] o_rxbd_status,
    output logic [7:0] o_rx_desc_ptr,
    output logic o_rx_valid,
    output logic [7:0] o_rx_data,
    output logic [15:0] o_events,
    output logic o_irq
);
    typedef struct packed {
        logic [4:0] s1;
        logic [4:0] s2;
        logic [4:0] s3;
        logic [4:0] f;
        tsc_pkg::tx_state_t ts;
        logic [5:0] pcnt;
        logic chain;
        logic gs_pend;
        logic stop_pend;
        logic [2:0] tbit;
        logic [7:0] tsh;
        logic [15:0] tsent;
        logic txd;
        logic take;
        logic poll;
        logic flush;
        logic [7:0] tptr;
        logic tclose;
        logic [1:0] tstat;
        tsc_pkg::rx_state_t rs;
        logic [2:0] rbit;
        logic [7:0] rsh;
        logic push;
        logic ovw;
        logic [7:0] pbyte;
        logic [15:0] rcnt;
        logic [15:0] crc;
        logic first;
        logic lenwr;
        logic stwr;
        logic [15:0] rstat;
        logic [15:0] rlen;
        logic [7:0] rptr;
        logic rint;
        logic ov_valid;
        logic [7:0] odata;
        logic [15:0] ev;
        logic irq;
    } ctl_st_t;

    ctl_st_t q, n;
    logic [15:0] evset;
    logic tx_edge, rx_edge, cts_ok, cd_on;
    logic hunt_cmd, close_cmd, tx_init, rx_init, do_close, go_hunt;
    logic [15:0] cst;
    logic [7:0] nbyte;
    logic f_wready, f_rvalid, f_rready, allow;
    logic [7:0] f_rdata;
    logic [3:0] f_count;

    function automatic logic [7:0] ptr_next(input logic [7:0] p, input logic wrap);
        ptr_next = wrap ? 8'h00 : p + 8'h01;
    endfunction

    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = (r[0] ^ b[i]) ? ((r >> 1) ^ tsc_pkg::CRC_POLY) : (r >> 1);
        end
        crc_byte = r;
    endfunction

    // Drain toward memory only once enough bytes are held, or after the frame
    assign allow = (f_count >= (i_rfw_narrow ? tsc_pkg::RX_THR_NARROW : tsc_pkg::RX_THR_WIDE))
        || (q.rs == tsc_pkg::RX_HUNT);
    assign f_rready = allow && (!q.ov_valid || i_rx_ready);

    rx_fifo #(.W(tsc_pkg::FIFO_W), .DEPTH(tsc_pkg::FIFO_DEPTH)) u_fifo (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_ce(i_ce),
        .i_wvalid(q.push),
        .o_wready(f_wready),
        .i_wdata(q.pbyte),
        .i_ovw(q.ovw),
        .o_rvalid(f_rvalid),
        .i_rready(f_rready),
        .o_rdata(f_rdata),
        .o_count(f_count)
    );

    // Whole controller next state; mode, command, pin and descriptor inputs steer it
    always_comb begin
        n = q;
        n.take = 1'b0;
        n.poll = 1'b0;
        n.flush = 1'b0;
        n.tclose = 1'b0;
        n.push = 1'b0;
        n.ovw = 1'b0;
        n.lenwr = 1'b0;
        n.stwr = 1'b0;
        evset = '0;
        hunt_cmd = 1'b0;
        close_cmd = 1'b0;
        tx_init = 1'b0;
        rx_init = 1'b0;
        do_close = 1'b0;
        go_hunt = 1'b0;
        cst = '0;
        // Three-stage sampling; a level counts once stages two and three agree
        n.s1 = {i_cd_n, i_cts_n, i_rxd, i_rxclk, i_txclk};
        n.s2 = q.s1;
        n.s3 = q.s2;
        n.f = (q.s2 & q.s3) | (q.f & (q.s2 ^ q.s3));
        nbyte = {n.f[2], q.rsh[7:1]};
        tx_edge = q.f[0] & ~n.f[0];
        rx_edge = ~q.f[1] & n.f[1];
        cts_ok = ~n.f[3];
        cd_on = ~n.f[4];
        if (i_cmd_valid) begin
            unique case (i_cmd)
                tsc_pkg::CMD_HUNT: hunt_cmd = 1'b1;
                tsc_pkg::CMD_CLOSE_RX: close_cmd = 1'b1;
                tsc_pkg::CMD_INIT_TX: tx_init = !i_tx_en;
                tsc_pkg::CMD_INIT_RX: rx_init = !i_rx_en;
                tsc_pkg::CMD_INIT_TXRX: begin
                    tx_init = !i_tx_en;
                    rx_init = !i_rx_en;
                end
                default: ;
            endcase
        end

        // Transmit sequencer; line idles high outside a buffer
        unique case (q.ts)
            tsc_pkg::TX_IDLE: begin
                n.txd = 1'b1;
                if (!i_tx_en) begin
                    n.pcnt = '0;
                end else if (i_tx_on_demand || q.pcnt == tsc_pkg::POLL_LAST) begin
                    n.poll = 1'b1;
                    n.pcnt = '0;
                    n.chain = 1'b0;
                    n.ts = tsc_pkg::TX_CHECK;
                end else begin
                    n.pcnt = q.pcnt + 6'h01;
                end
            end
            tsc_pkg::TX_CHECK: begin
                if (i_txbd_ready) begin
                    n.ts = tsc_pkg::TX_SEND;
                    n.tsent = '0;
                    n.tbit = '0;
                end else if (q.chain) begin
                    evset[tsc_pkg::EV_TXE] = 1'b1;
                    n.ts = tsc_pkg::TX_HALT;
                end else begin
                    n.ts = tsc_pkg::TX_IDLE;
                end
            end
            tsc_pkg::TX_SEND: begin
                if (!cts_ok) begin
                    n.tclose = 1'b1;
                    n.tstat = 2'h0;
                    n.tstat[tsc_pkg::TXS_CT] = 1'b1;
                    evset[tsc_pkg::EV_TXE] = 1'b1;
                    n.txd = 1'b1;
                    n.ts = tsc_pkg::TX_HALT;
                end else if (tx_edge) begin
                    if (q.tbit != 3'h0) begin
                        n.txd = q.tsh[0];
                        n.tsh = q.tsh >> 1;
                        n.tbit = q.tbit - 3'h1;
                    end else if (q.stop_pend) begin
                        // Abort at a byte boundary, well inside the bit budget
                        n.flush = 1'b1;
                        n.txd = 1'b1;
                        n.stop_pend = 1'b0;
                        n.ts = tsc_pkg::TX_HALT;
                    end else if (q.tsent == i_txbd_len) begin
                        n.tclose = 1'b1;
                        n.tstat = 2'h0;
                        n.tptr = ptr_next(q.tptr, i_txbd_wrap);
                        n.txd = 1'b1;
                        evset[tsc_pkg::EV_TX] = i_txbd_int;
                        if (i_txbd_last && q.gs_pend) begin
                            evset[tsc_pkg::EV_GRA] = 1'b1;
                            n.gs_pend = 1'b0;
                            n.ts = tsc_pkg::TX_HALT;
                        end else if (i_txbd_last) begin
                            n.pcnt = '0;
                            n.ts = tsc_pkg::TX_IDLE;
                        end else begin
                            n.poll = 1'b1;
                            n.chain = 1'b1;
                            n.ts = tsc_pkg::TX_CHECK;
                        end
                    end else if (i_tx_byte_valid) begin
                        n.take = 1'b1;
                        n.txd = i_tx_byte[0];
                        n.tsh = {1'b0, i_tx_byte[7:1]};
                        n.tbit = 3'h7;
                        n.tsent = q.tsent + 16'h0001;
                    end else begin
                        n.tclose = 1'b1;
                        n.tstat = 2'h0;
                        n.tstat[tsc_pkg::TXS_UN] = 1'b1;
                        evset[tsc_pkg::EV_TXE] = 1'b1;
                        n.txd = 1'b1;
                        n.ts = tsc_pkg::TX_HALT;
                    end
                end
            end
            tsc_pkg::TX_HALT: n.txd = 1'b1;
        endcase

        // Transmit commands override the sequencer
        if (i_cmd_valid && i_cmd == tsc_pkg::CMD_STOP_TX) begin
            if (q.ts == tsc_pkg::TX_SEND) begin
                n.stop_pend = 1'b1;
            end else begin
                n.ts = tsc_pkg::TX_HALT;
            end
        end
        if (i_cmd_valid && i_cmd == tsc_pkg::CMD_GSTOP_TX) begin
            if (q.ts == tsc_pkg::TX_SEND || (q.ts == tsc_pkg::TX_CHECK && q.chain)) begin
                n.gs_pend = 1'b1;
            end else if (q.ts != tsc_pkg::TX_HALT) begin
                evset[tsc_pkg::EV_GRA] = 1'b1;
                n.ts = tsc_pkg::TX_HALT;
            end
        end
        // Restart resumes polling at the kept pointer; a ready bit is still needed
        if (i_cmd_valid && i_cmd == tsc_pkg::CMD_RESTART_TX && q.ts == tsc_pkg::TX_HALT) begin
            n.ts = tsc_pkg::TX_IDLE;
            n.pcnt = '0;
            n.stop_pend = 1'b0;
            n.gs_pend = 1'b0;
        end
        if (tx_init) begin
            n.ts = tsc_pkg::TX_IDLE;
            n.pcnt = '0;
            n.tptr = '0;
            n.chain = 1'b0;
            n.stop_pend = 1'b0;
            n.gs_pend = 1'b0;
        end

        // Receive: carrier loss checked first, then hunt command, then data, then close command
        if (q.rs == tsc_pkg::RX_RECV) begin
            if (!cd_on || !i_rx_en) begin
                do_close = 1'b1;
                cst[tsc_pkg::RXS_CDL] = !cd_on;
                cst[tsc_pkg::RXS_LAST] = 1'b1;
                cst[tsc_pkg::RXS_NONOCT] = (q.rbit != 3'h0);
                go_hunt = 1'b1;
            end else if (hunt_cmd) begin
                do_close = 1'b1;
                cst[tsc_pkg::RXS_LAST] = 1'b1;
                cst[tsc_pkg::RXS_CRCERR] = (q.crc != i_crc_const);
                cst[tsc_pkg::RXS_NONOCT] = (q.rbit != 3'h0);
                go_hunt = 1'b1;
            end else if (rx_edge) begin
                n.rsh = nbyte;
                n.rbit = q.rbit + 3'h1;
                if (q.rbit == 3'h7) begin
                    n.pbyte = nbyte;
                    if (!f_wready) begin
                        n.ovw = 1'b1;
                        do_close = 1'b1;
                        cst[tsc_pkg::RXS_OVR] = 1'b1;
                        cst[tsc_pkg::RXS_LAST] = 1'b1;
                        go_hunt = 1'b1;
                    end else begin
                        n.push = 1'b1;
                        n.crc = crc_byte(q.crc, nbyte);
                        n.rcnt = q.rcnt + 16'h0001;
                        do_close = (n.rcnt == i_rx_max_len);
                    end
                end
            end else if (close_cmd) begin
                do_close = 1'b1;
            end
        end else if (i_rx_en && cd_on) begin
            n.rs = tsc_pkg::RX_RECV;
            n.rbit = '0;
            n.rcnt = '0;
            n.crc = i_crc_preset;
            n.first = 1'b1;
        end

        // Closing writes length first; status with the empty bit follows
        if (do_close) begin
            n.lenwr = 1'b1;
            n.rlen = n.rcnt;
            n.rstat = cst;
            n.rstat[tsc_pkg::RXS_FIRST] = q.first;
            n.rstat[tsc_pkg::RXS_WRAP] = i_rxbd_wrap;
            n.rstat[tsc_pkg::RXS_INT] = i_rxbd_int;
            n.rstat[tsc_pkg::RXS_CONT] = i_rxbd_cont;
            // CRC, overrun and carrier-loss errors always return the descriptor, even in continuous use
            n.rstat[tsc_pkg::RXS_EMPTY] = i_rxbd_cont && !(|cst[2:0]);
            n.rint = i_rxbd_int;
            n.rcnt = '0;
            n.first = 1'b0;
        end
        if (go_hunt) begin
            n.rs = tsc_pkg::RX_HUNT;
        end
        if (q.lenwr) begin
            n.stwr = 1'b1;
            n.rptr = ptr_next(q.rptr, q.rstat[tsc_pkg::RXS_WRAP]);
            evset[tsc_pkg::EV_RX] = q.rint;
        end
        if (rx_init) begin
            n.rs = tsc_pkg::RX_HUNT;
            n.rptr = '0;
            n.rcnt = '0;
        end

        // Output stage toward memory
        if (f_rready && f_rvalid) begin
            n.ov_valid = 1'b1;
            n.odata = f_rdata;
        end else if (i_rx_ready) begin
            n.ov_valid = 1'b0;
        end

        // A new event beats a clear arriving in the same cycle
        n.ev = (q.ev & ~i_ev_clr) | evset;
        n.irq = |(n.ev & i_ev_mask);
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            // Samplers start at idle pin levels, so no false carrier or edge follows reset
            q <= '0;
            q.s1 <= tsc_pkg::PIN_IDLE;
            q.s2 <= tsc_pkg::PIN_IDLE;
            q.s3 <= tsc_pkg::PIN_IDLE;
            q.f <= tsc_pkg::PIN_IDLE;
        end else if (i_ce) begin
            q <= n;
        end
    end

    // Every output is a field of the state register
    assign o_txd = q.txd;
    assign o_tx_poll = q.poll;
    assign o_tx_byte_take = q.take;
    assign o_tx_flush = q.flush;
    assign o_txbd_close = q.tclose;
    assign o_txbd_status = q.tstat;
    assign o_tx_desc_ptr = q.tptr;
    assign o_rxbd_len_wr = q.lenwr;
    assign o_rxbd_len = q.rlen;
    assign o_rxbd_status_wr = q.stwr;
    assign o_rxbd_status = q.rstat;
    assign o_rx_desc_ptr = q.rptr;
    assign o_rx_valid = q.ov_valid;
    assign o_rx_data = q.odata;
    assign o_events = q.ev;
    assign o_irq = q.irq;

    // Checks of the controller against its own ports
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    a_len_then_status: assert property (q.lenwr && i_ce |=> q.stwr)
        else $error("status write did not follow length write");
    a_status_has_len: assert property (q.stwr |-> $past(q.lenwr))
        else $error("status written without length first");
    a_poll_gap: assert property (q.ts == tsc_pkg::TX_IDLE && i_tx_en && !i_tx_on_demand
        && q.pcnt < tsc_pkg::POLL_LAST && i_ce |=> !q.poll)
        else $error("descriptor polled early");
    a_stop_flush_halt: assert property (q.flush |-> q.ts == tsc_pkg::TX_HALT && q.txd)
        else $error("flush without halt and idle line");
    a_gra_halted: assert property ($rose(q.ev[tsc_pkg::EV_GRA]) |-> q.ts == tsc_pkg::TX_HALT)
        else $error("graceful stop flag without halt");
    a_halt_holds: assert property (q.ts == tsc_pkg::TX_HALT && !i_cmd_valid && i_ce
        |=> q.ts == tsc_pkg::TX_HALT)
        else $error("transmitter left halt without restart");
    a_ovr_hunt: assert property (q.lenwr && q.rstat[tsc_pkg::RXS_OVR] |-> q.rs == tsc_pkg::RX_HUNT
        && !q.rstat[tsc_pkg::RXS_EMPTY])
        else $error("overrun close without hunt");
    a_cd_alone: assert property (q.lenwr && q.rstat[tsc_pkg::RXS_CDL]
        |-> q.rstat[2:1] == 2'h0 && q.rs == tsc_pkg::RX_HUNT)
        else $error("carrier loss close with other errors");
    a_irq_level: assert property (i_ce |=> q.irq == |(q.ev & $past(i_ev_mask)))
        else $error("interrupt does not follow unmasked events");

    c_tx_close: cover property (q.tclose && q.tstat == 2'h0);
    c_rx_overrun: cover property (q.lenwr && q.rstat[tsc_pkg::RXS_OVR]);
    c_graceful: cover property ($rose(q.ev[tsc_pkg::EV_GRA]));
endmodule

// file: hdl/tsc_pkg.sv
// Constants and types for the transparent serial channel controller.
// Assumes one 100 MHz system clock; link pins are sampled, not clocked.
package tsc_pkg;
    // Timing
    localparam int CLK_MHZ = 100;
    localparam int POLL_CLOCKS = 64;
    localparam logic [5:0] POLL_LAST = 6'(POLL_CLOCKS - 1);
    // Idle pin levels {cd_n, cts_n, rxd, rxclk, txclk}: no carrier, not clear, line high
    localparam logic [4:0] PIN_IDLE = 5'h1C;
    // Receive buffering and transfer thresholds in bytes
    localparam int FIFO_W = 8;
    localparam int FIFO_DEPTH = 8;
    localparam logic [3:0] RX_THR_NARROW = 4'h1;
    localparam logic [3:0] RX_THR_WIDE = 4'h4;
    // Command codes
    localparam logic [2:0] CMD_STOP_TX = 3'h0;
    localparam logic [2:0] CMD_GSTOP_TX = 3'h1;
    localparam logic [2:0] CMD_RESTART_TX = 3'h2;
    localparam logic [2:0] CMD_INIT_TX = 3'h3;
    localparam logic [2:0] CMD_INIT_TXRX = 3'h4;
    localparam logic [2:0] CMD_HUNT = 3'h5;
    localparam logic [2:0] CMD_CLOSE_RX = 3'h6;
    localparam logic [2:0] CMD_INIT_RX = 3'h7;
    // Event register bit positions
    localparam int EV_RX = 0;
    localparam int EV_TX = 1;
    localparam int EV_TXE = 4;
    localparam int EV_GRA = 7;
    // Receive descriptor status bits
    localparam int RXS_EMPTY = 15;
    localparam int RXS_WRAP = 13;
    localparam int RXS_INT = 12;
    localparam int RXS_LAST = 11;
    localparam int RXS_FIRST = 10;
    localparam int RXS_CONT = 9;
    localparam int RXS_DECERR = 7;
    localparam int RXS_NONOCT = 4;
    localparam int RXS_CRCERR = 2;
    localparam int RXS_OVR = 1;
    localparam int RXS_CDL = 0;
    // Transmit descriptor error bits as reported on close
    localparam int TXS_UN = 1;
    localparam int TXS_CT = 0;
    // CRC: receive polynomial (reflected CCITT) and software load values
    localparam logic [15:0] CRC_POLY = 16'h8408;
    localparam logic [31:0] CRC_PRESET_CCITT16 = 32'h0000FFFF;
    localparam logic [31:0] CRC_CONST_CCITT16 = 32'h0000F0B8;
    localparam logic [31:0] CRC_CONST_CCITT32 = 32'hDEBB20E3;
    localparam logic [31:0] CRC_ZERO = 32'h00000000;
    typedef enum logic [1:0] {TX_IDLE, TX_CHECK, TX_SEND, TX_HALT} tx_state_t;
    typedef enum logic {RX_HUNT, RX_RECV} rx_state_t;
endpackage

// file: sim/serial_peer.sv
// Far-side serial peer: drives receive clock, data, carrier and clear-to-send.
// Assumes the bench calls its tasks; the clock stands still outside frames.
`timescale 1ns/1ns
module serial_peer (
    output logic o_rxclk,
    output logic o_rxd,
    output logic o_cd_n,
    output logic o_cts_n
);
    initial begin
        o_rxclk = 1'b0;
        o_rxd = 1'b1;
        o_cd_n = 1'b1;
        o_cts_n = 1'b0;
    end
    // LSB first at 125 ns a bit; stale data is inverted, never held
    task automatic send_byte(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            o_rxd = b[i];
            #63 o_rxclk = 1'b1;
            #62 o_rxclk = 1'b0;
        end
        o_rxd = ~o_rxd;
    endtask
    // Carrier frames the message
    task automatic carrier(input logic on);
        #100 o_cd_n = ~on;
        #100;
    endtask
endmodule

// file: sim/testbench.sv
// Bench: commands, event clearing and receive closes at the block's ports.
// Assumes the serial peer model for receive; the bench clocks one transmit buffer.
`timescale 1ns/1ns
module testbench;
    logic i_clk, i_nrst, i_ce, i_tx_en, i_rx_en, i_rfw_narrow, i_tx_on_demand, i_cmd_valid;
    logic [2:0] i_cmd;
    logic [15:0] i_ev_clr, i_ev_mask, i_crc_preset, i_crc_const, i_txbd_len, i_rx_max_len;
    logic i_txclk, i_txbd_ready, i_txbd_last, i_txbd_wrap, i_txbd_int, i_tx_byte_valid;
    logic [7:0] i_tx_byte;
    logic i_rxbd_wrap, i_rxbd_int, i_rxbd_cont, i_rx_ready, i_rxclk, i_rxd, i_cd_n, i_cts_n;
    logic o_txd, o_tx_poll, o_tx_byte_take, o_tx_flush, o_txbd_close, o_rxbd_len_wr;
    logic o_rxbd_status_wr, o_rx_valid, o_irq;
    logic [1:0] o_txbd_status;
    logic [7:0] o_tx_desc_ptr, o_rx_desc_ptr, o_rx_data;
    logic [15:0] o_rxbd_len, o_rxbd_status, o_events;
    int failures = 0;
    int num_checks = 0;
    int n;
    logic [7:0] rxq[$];
    logic [15:0] clen[$], cst[$];
    logic [11:0] txq[$];
    logic b;
    logic [8:0] tb;
    transparent_serial_channel_control transparent_serial_channel_control_inst (.*);
    serial_peer serial_peer_inst (.o_rxclk(i_rxclk), .o_rxd(i_rxd), .o_cd_n(i_cd_n), .o_cts_n(i_cts_n));
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // Record bytes and descriptor writes as the design hands them over
    always @(posedge i_clk) begin
        if (o_rx_valid && i_rx_ready) rxq.push_back(o_rx_data);
        if (o_rxbd_len_wr) clen.push_back(o_rxbd_len);
        if (o_rxbd_status_wr) cst.push_back(o_rxbd_status);
        if (o_tx_byte_take || o_txbd_close) txq.push_back({o_tx_byte_take, o_txbd_close, o_txbd_status, o_tx_desc_ptr});
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic cmd(input logic [2:0] c);
        @(negedge i_clk) i_cmd = c;
        i_cmd_valid = 1'b1;
        @(negedge i_clk) i_cmd_valid = 1'b0;
    endtask
    // One 125 ns link bit: the fall launches a bit, read mid-bit as the clock rises
    task automatic tx_bit(output logic bit_o);
        i_txclk = 1'b0;
        #62 bit_o = o_txd;
        i_txclk = 1'b1;
        #63;
    endtask
    // Cycles until the next descriptor fetch; a lost poll ends the run
    task automatic wait_poll(output int cnt);
        cnt = 0;
        while (!o_tx_poll) begin
            @(negedge i_clk) cnt++;
            if (cnt > 200) begin
                failures++;
                summarize();
            end
        end
    endtask
    initial begin
        {i_nrst, i_cmd_valid, i_cmd, i_ev_clr, i_tx_on_demand, i_txbd_ready} = '0;
        {i_txbd_last, i_txbd_wrap, i_txbd_int, i_tx_byte_valid, i_tx_byte, i_txbd_len} = '0;
        {i_rxbd_wrap, i_rxbd_cont} = '0;
        {i_ce, i_tx_en, i_rx_en, i_rfw_narrow, i_rxbd_int, i_rx_ready, i_txclk} = '1;
        i_ev_mask = 16'h0081;
        i_crc_preset = 16'hFFFF;
        i_crc_const = 16'hF0B8;
        i_rx_max_len = 16'h0002;
        repeat (8) @(posedge i_clk);
        @(negedge i_clk) i_nrst = 1'b1;
        chk(o_events, 16'h0000);
        cmd(tsc_pkg::CMD_CLOSE_RX);
        repeat (4) @(negedge i_clk);
        chk(16'(clen.size()), 16'h0000);
        cmd(tsc_pkg::CMD_GSTOP_TX);
        chk(16'(o_events[tsc_pkg::EV_GRA]), 16'h0001);
        @(negedge i_clk) i_ev_clr = 16'h0080;
        chk(16'(o_irq), 16'h0001);
        @(negedge i_clk) i_ev_clr = 16'h0000;
        @(negedge i_clk);
        chk({o_events[15:1], o_irq}, 16'h0000);
        // Restart leaves the halt and polling resumes on the 64-clock beat
        cmd(tsc_pkg::CMD_RESTART_TX);
        wait_poll(n);
        chk(16'(n >= 60 && n <= 66), 16'h0001);
        i_tx_on_demand = 1'b1;
        @(negedge i_clk);
        wait_poll(n);
        chk(16'(n <= 3), 16'h0001);
        i_tx_on_demand = 1'b0;
        // One-byte buffer, not last in frame; the chained fetch then finds nothing ready
        {i_txbd_ready, i_txbd_len, i_tx_byte_valid, i_tx_byte} = {1'b1, 16'h0001, 1'b1, 8'hA6};
        #2;
        for (int i = 0; i < 9; i++) begin
            tx_bit(b);
            tb = {b, tb[8:1]};
            {i_txbd_ready, i_tx_byte_valid} = 2'h0;
        end
        repeat (4) @(negedge i_clk);
        chk(16'(tb), 16'h01A6);
        chk(16'(txq[0]), 16'h0800);
        chk(16'(txq[1]), 16'h0401);
        chk(16'(o_events[tsc_pkg::EV_TXE]), 16'h0001);
        // Three bytes into two-byte buffers, then carrier drops mid-buffer
        serial_peer_inst.carrier(1'b1);
        for (int i = 0; i < 3; i++) serial_peer_inst.send_byte(8'({8'h81, 8'h3C, 8'hA5} >> (8 * i)));
        serial_peer_inst.carrier(1'b0);
        repeat (20) @(negedge i_clk);
        chk({rxq[0], rxq[1]}, 16'hA53C);
        chk(16'(rxq[2]), 16'h0081);
        chk(clen[0], 16'h0002);
        chk(cst[0] & 16'h8003, 16'h0000);
        chk(clen[1], 16'h0001);
        chk(cst[1] & 16'h8003, 16'h0001);
        chk(16'(o_rx_desc_ptr), 16'h0002);
        chk(16'(o_events[tsc_pkg::EV_RX]), 16'h0001);
        summarize();
    end
endmodule
